/* src/trm_map.svh */
// Register offsets, field positions, reset values and counts for the temperature monitor.
`ifndef TRM_MAP_SVH
`define TRM_MAP_SVH
`define TRM_A_LOCAL 8'h00
`define TRM_A_RA_HI 8'h01
`define TRM_A_RA_LO 8'h10
`define TRM_A_RB_HI 8'h30
`define TRM_A_RB_LO 8'h33
`define TRM_A_STATUS 8'h02
`define TRM_A_CFG_RD 8'h03
`define TRM_A_CFG_WR 8'h09
`define TRM_A_RATE_RD 8'h04
`define TRM_A_RATE_WR 8'h0a
`define TRM_A_OTSTAT 8'h23
`define TRM_A_LIM_BASE 8'h40
`define TRM_LIM_COUNT 8'h09
`define TRM_PTR_RST 8'h00
`define TRM_CFG_MASK_ALL 7
`define TRM_CFG_STANDBY 6
`define TRM_CFG_ROLE 5
`define TRM_CFG_ALIAS 3
`define TRM_CFG_RANGE 2
`define TRM_CFG_MASK_RA 1
`define TRM_CFG_MASK_RB 0
`define TRM_CFG_WMASK 8'hef
`define TRM_CFG_RST 8'h00
`define TRM_RATE_NOAVG 7
`define TRM_RATE_FAST_MIN 4'h8
`define TRM_RATE_RST 8'h08
`define TRM_LIM_HI_RST 8'h55
`define TRM_LIM_LO_RST 8'h00
`define TRM_LIM_OT_RST 8'h55
`define TRM_AVG_LAST 4'hf
`define TRM_AVG_SHIFT 4
`define TRM_EXT_OFFSET_Q 12'sh100
`define TRM_BIN_MAX_Q 12'sh1ff
`define TRM_EXT_MAX_Q 12'sh3ff
`define TRM_BIN_CLAMP 10'h1fc
`define TRM_EXT_CLAMP 10'h3ff
`endif

/* src/trm_pkg.sv */
// Types shared by the temperature monitor.
package trm_pkg;
  typedef logic signed [11:0] trm_sample_t;
  typedef enum logic [2:0] {
    SB_IDLE = 3'b000,
    SB_ADDR = 3'b001,
    SB_AACK = 3'b010,
    SB_WRITE = 3'b011,
    SB_WACK = 3'b100,
    SB_READ = 3'b101,
    SB_RACK = 3'b110
  } trm_bus_st_t;
  typedef enum logic [1:0] {
    SQ_START = 2'b00,
    SQ_WAIT = 2'b01,
    SQ_STORE = 2'b10
  } trm_seq_st_t;
  typedef enum logic [1:0] {
    CH_LOCAL = 2'b00,
    CH_REM_A = 2'b01,
    CH_REM_B = 2'b10
  } trm_chan_t;
endpackage

/* src/trm_top.sv */
// Temperature monitor back end: sequencer, formatting, limits, alarms and two-wire slave.
`timescale 1ns/1ps
`include "trm_map.svh"
module trm_top #(
  parameter logic [6:0] SLAVE_ADDR = 7'h2a
) (
  input wire logic core_clk_i,
  input wire logic reset_i,
  input wire logic scl_i,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe_n_o,
  output logic overtemp_out_n_o,
  output logic overtemp_oe_n_o,
  output logic alert_out_n_o,
  output logic alert_oe_n_o,
  input wire logic adc_clk_i,
  output logic adc_start_o,
  output trm_pkg::trm_chan_t adc_chan_o,
  input wire logic adc_done_i,
  input wire trm_pkg::trm_sample_t adc_data_i,
  input wire logic adc_open_i
);
  import trm_pkg::*;

  function automatic logic [9:0] fmt_q(input trm_sample_t q, input logic ext);
    trm_sample_t t;
    logic [9:0] r;
    t = ext ? q + `TRM_EXT_OFFSET_Q : q;
    if (t < 0) begin
      r = 10'h000;
    end else if (!ext && t > `TRM_BIN_MAX_Q) begin
      r = `TRM_BIN_CLAMP;
    end else if (ext && t > `TRM_EXT_MAX_Q) begin
      r = `TRM_EXT_CLAMP;
    end else begin
      r = t[9:0];
    end
    return r;
  endfunction

  function automatic logic [7:0] lim_rst(input int idx);
    logic [7:0] r;
    if (idx % 3 == 0) begin
      r = `TRM_LIM_HI_RST;
    end else if (idx % 3 == 1) begin
      r = `TRM_LIM_LO_RST;
    end else begin
      r = `TRM_LIM_OT_RST;
    end
    return r;
  endfunction

  // Link side: the front end runs on its own clock and answers one request at a time.
  logic arst_s1_q, arst_s2_q;
  logic rq_s1_q, rq_s2_q, rq_s3_q;
  logic busy_a_q, ack_a_q, start_a_q;
  trm_chan_t chan_a_q;
  trm_sample_t data_a_q;
  logic open_a_q;
  logic req_tgl_q;
  trm_chan_t chan_c_q;
  wire new_req_a = rq_s2_q ^ rq_s3_q;

  always_ff @(posedge adc_clk_i) begin
    arst_s1_q <= reset_i;
    arst_s2_q <= arst_s1_q;
  end

  always_ff @(posedge adc_clk_i) begin
    if (arst_s2_q) begin
      rq_s1_q <= 1'b0;
      rq_s2_q <= 1'b0;
      rq_s3_q <= 1'b0;
      busy_a_q <= 1'b0;
      ack_a_q <= 1'b0;
      start_a_q <= 1'b0;
      chan_a_q <= CH_LOCAL;
      data_a_q <= 12'sh000;
      open_a_q <= 1'b0;
    end else begin
      rq_s1_q <= req_tgl_q;
      rq_s2_q <= rq_s1_q;
      rq_s3_q <= rq_s2_q;
      start_a_q <= new_req_a;
      if (new_req_a) begin
        chan_a_q <= chan_c_q;
        busy_a_q <= 1'b1;
      end else if (busy_a_q && adc_done_i) begin
        data_a_q <= adc_data_i;
        open_a_q <= adc_open_i;
        ack_a_q <= ~ack_a_q;
        busy_a_q <= 1'b0;
      end
    end
  end

  assign adc_start_o = start_a_q;
  assign adc_chan_o = chan_a_q;

  // Core side of the handshake and pin synchronisers.
  logic ack_s1_q, ack_s2_q, ack_s3_q;
  logic scl_s1_q, scl_s2_q, scl_s3_q;
  logic sda_s1_q, sda_s2_q, sda_s3_q;
  wire ack_edge = ack_s2_q ^ ack_s3_q;

  always_ff @(posedge core_clk_i) begin
    if (reset_i) begin
      ack_s1_q <= 1'b0;
      ack_s2_q <= 1'b0;
      ack_s3_q <= 1'b0;
      scl_s1_q <= 1'b1;
      scl_s2_q <= 1'b1;
      scl_s3_q <= 1'b1;
      sda_s1_q <= 1'b1;
      sda_s2_q <= 1'b1;
      sda_s3_q <= 1'b1;
    end else begin
      ack_s1_q <= ack_a_q;
      ack_s2_q <= ack_s1_q;
      ack_s3_q <= ack_s2_q;
      scl_s1_q <= scl_i;
      scl_s2_q <= scl_s1_q;
      scl_s3_q <= scl_s2_q;
      sda_s1_q <= sda_i;
      sda_s2_q <= sda_s1_q;
      sda_s3_q <= sda_s2_q;
    end
  end

  wire scl_rise = scl_s2_q & ~scl_s3_q;
  wire scl_fall = ~scl_s2_q & scl_s3_q;
  wire start_w = scl_s2_q & scl_s3_q & sda_s3_q & ~sda_s2_q;
  wire stop_w = scl_s2_q & scl_s3_q & ~sda_s3_q & sda_s2_q;

  // Registers.
  logic [7:0] cfg_q, rate_q, loc_q;
  logic [7:0] lim_q [0:8];
  logic [7:0] hi_lat_q [0:1];
  logic [7:0] frz_q [0:1];
  logic [1:0] lo_lat_q [0:1];
  logic [1:0] pend_q, lock_q;
  logic [2:0] hf_q, lf_q, of_q;
  logic [1:0] open_q;

  // Two-wire slave.
  trm_bus_st_t sb_q;
  logic [3:0] bit_q;
  logic [7:0] sh_q, ptr_q, rd_byte;
  logic rnw_q, first_q, sda_oe_n_q, mack_q, wr_pulse_q, rd_pulse_q;

  always_ff @(posedge core_clk_i) begin
    if (reset_i) begin
      sb_q <= SB_IDLE;
      bit_q <= 4'h0;
      sh_q <= 8'h00;
      ptr_q <= `TRM_PTR_RST;
      rnw_q <= 1'b0;
      first_q <= 1'b0;
      sda_oe_n_q <= 1'b1;
      mack_q <= 1'b0;
      wr_pulse_q <= 1'b0;
      rd_pulse_q <= 1'b0;
    end else begin
      wr_pulse_q <= 1'b0;
      rd_pulse_q <= 1'b0;
      if (start_w) begin
        sb_q <= SB_ADDR;
        bit_q <= 4'h0;
        sda_oe_n_q <= 1'b1;
      end else if (stop_w) begin
        sb_q <= SB_IDLE;
        sda_oe_n_q <= 1'b1;
      end else begin
        case (sb_q)
          SB_ADDR: begin
            if (scl_rise) begin
              sh_q <= {sh_q[6:0], sda_s2_q};
              bit_q <= bit_q + 4'h1;
            end else if (scl_fall && bit_q == 4'h8) begin
              if (sh_q[7:1] == SLAVE_ADDR) begin
                rnw_q <= sh_q[0];
                sda_oe_n_q <= 1'b0;
                sb_q <= SB_AACK;
              end else begin
                sb_q <= SB_IDLE;
              end
            end
          end
          SB_AACK, SB_RACK: begin
            if (sb_q == SB_RACK && scl_rise) begin
              mack_q <= ~sda_s2_q;
            end else if (scl_fall) begin
              bit_q <= 4'h0;
              if (sb_q == SB_AACK && !rnw_q) begin
                sda_oe_n_q <= 1'b1;
                first_q <= 1'b1;
                sb_q <= SB_WRITE;
              end else if (sb_q == SB_AACK || mack_q) begin
                sh_q <= rd_byte;
                sda_oe_n_q <= rd_byte[7];
                rd_pulse_q <= 1'b1;
                sb_q <= SB_READ;
              end else begin
                sda_oe_n_q <= 1'b1;
                sb_q <= SB_IDLE;
              end
            end
          end
          SB_WRITE: begin
            if (scl_rise) begin
              sh_q <= {sh_q[6:0], sda_s2_q};
              bit_q <= bit_q + 4'h1;
            end else if (scl_fall && bit_q == 4'h8) begin
              if (first_q) begin
                ptr_q <= sh_q;
              end else begin
                wr_pulse_q <= 1'b1;
              end
              first_q <= 1'b0;
              sda_oe_n_q <= 1'b0;
              sb_q <= SB_WACK;
            end
          end
          SB_WACK: begin
            if (scl_fall) begin
              sda_oe_n_q <= 1'b1;
              bit_q <= 4'h0;
              sb_q <= SB_WRITE;
            end
          end
          SB_READ: begin
            if (scl_fall) begin
              if (bit_q == 4'h7) begin
                sda_oe_n_q <= 1'b1;
                sb_q <= SB_RACK;
              end else begin
                sh_q <= {sh_q[6:0], 1'b0};
                sda_oe_n_q <= sh_q[6];
                bit_q <= bit_q + 4'h1;
              end
            end
          end
          default: begin
            sda_oe_n_q <= 1'b1;
          end
        endcase
      end
    end
  end

  assign sda_oe_n_o = sda_oe_n_q;

  // Address decode and read selection.
  wire alias_w = cfg_q[`TRM_CFG_ALIAS];
  wire lim_hit_w = ptr_q >= `TRM_A_LIM_BASE && ptr_q < `TRM_A_LIM_BASE + `TRM_LIM_COUNT;
  wire [7:0] lim_off_w = ptr_q - `TRM_A_LIM_BASE;
  wire [3:0] lim_idx_w = lim_off_w[3:0];
  wire [7:0] hi_vis_a = lock_q[0] ? frz_q[0] : hi_lat_q[0];
  wire [7:0] hi_vis_b = lock_q[1] ? frz_q[1] : hi_lat_q[1];
  wire [7:0] status_w = {open_q[1], lf_q[2], hf_q[2], open_q[0], lf_q[1], hf_q[1], lf_q[0], hf_q[0]};
  wire [7:0] otstat_w = {5'h00, of_q};
  wire at_ra_lo = ptr_q == `TRM_A_RA_LO;
  wire at_ra_hi = ptr_q == `TRM_A_RA_HI;
  wire [1:0] lo_rd_w = {rd_pulse_q & ((at_ra_lo & alias_w) | ptr_q == `TRM_A_RB_LO),
                        rd_pulse_q & at_ra_lo & ~alias_w};
  wire [1:0] hi_rd_w = {rd_pulse_q & ((at_ra_hi & alias_w) | ptr_q == `TRM_A_RB_HI),
                        rd_pulse_q & at_ra_hi & ~alias_w};

  always_comb begin
    if (ptr_q == `TRM_A_LOCAL) begin
      rd_byte = loc_q;
    end else if (at_ra_hi) begin
      rd_byte = alias_w ? hi_vis_b : hi_vis_a;
    end else if (at_ra_lo) begin
      rd_byte = {alias_w ? lo_lat_q[1] : lo_lat_q[0], 6'h00};
    end else if (ptr_q == `TRM_A_RB_HI) begin
      rd_byte = hi_vis_b;
    end else if (ptr_q == `TRM_A_RB_LO) begin
      rd_byte = {lo_lat_q[1], 6'h00};
    end else if (ptr_q == `TRM_A_STATUS) begin
      rd_byte = status_w;
    end else if (ptr_q == `TRM_A_CFG_RD) begin
      rd_byte = cfg_q;
    end else if (ptr_q == `TRM_A_RATE_RD) begin
      rd_byte = rate_q;
    end else if (ptr_q == `TRM_A_OTSTAT) begin
      rd_byte = otstat_w;
    end else if (lim_hit_w) begin
      rd_byte = lim_q[lim_idx_w];
    end else begin
      rd_byte = 8'h00;
    end
  end

  // Host-written registers; a range change touches no limit.
  always_ff @(posedge core_clk_i) begin
    if (reset_i) begin
      cfg_q <= `TRM_CFG_RST;
      rate_q <= `TRM_RATE_RST;
      for (int i = 0; i < 9; i++) begin
        lim_q[i] <= lim_rst(i);
      end
    end else if (wr_pulse_q) begin
      if (ptr_q == `TRM_A_CFG_WR) begin
        cfg_q <= sh_q & `TRM_CFG_WMASK;
      end else if (ptr_q == `TRM_A_RATE_WR) begin
        rate_q <= sh_q;
      end else if (lim_hit_w) begin
        lim_q[lim_idx_w] <= sh_q;
      end
    end
  end

  // High-byte lock: armed by a low read, engaged only by a stop, released by the high read.
  always_ff @(posedge core_clk_i) begin
    if (reset_i) begin
      pend_q <= 2'b00;
      lock_q <= 2'b00;
      frz_q[0] <= 8'h00;
      frz_q[1] <= 8'h00;
    end else begin
      for (int c = 0; c < 2; c++) begin
        if (lo_rd_w[c]) begin
          pend_q[c] <= 1'b1;
          if (!lock_q[c]) begin
            frz_q[c] <= hi_lat_q[c];
          end
        end else if (start_w) begin
          pend_q[c] <= 1'b0;
        end else if (stop_w && pend_q[c]) begin
          pend_q[c] <= 1'b0;
          lock_q[c] <= 1'b1;
        end
        if (hi_rd_w[c]) begin
          lock_q[c] <= 1'b0;
        end
      end
    end
  end

  // Conversion sequencer.
  trm_seq_st_t sq_q;
  trm_chan_t ch_q;
  logic [3:0] cnt_q;
  logic signed [15:0] acc_q;
  logic opn_q, avg_q;
  wire standby_select = cfg_q[`TRM_CFG_STANDBY];
  wire pin_role_select = cfg_q[`TRM_CFG_ROLE];
  wire avg_en_w = ~rate_q[`TRM_RATE_NOAVG] & (rate_q[3:0] < `TRM_RATE_FAST_MIN);

  always_ff @(posedge core_clk_i) begin
    if (reset_i) begin
      sq_q <= SQ_START;
      ch_q <= CH_LOCAL;
      cnt_q <= 4'h0;
      acc_q <= 16'sh0000;
      opn_q <= 1'b0;
      avg_q <= 1'b0;
      req_tgl_q <= 1'b0;
      chan_c_q <= CH_LOCAL;
    end else begin
      case (sq_q)
        SQ_START: begin
          if (!standby_select) begin
            req_tgl_q <= ~req_tgl_q;
            chan_c_q <= ch_q;
            if (cnt_q == 4'h0) begin
              avg_q <= avg_en_w;
            end
            sq_q <= SQ_WAIT;
          end
        end
        SQ_WAIT: begin
          if (ack_edge) begin
            acc_q <= acc_q + {{4{data_a_q[11]}}, data_a_q};
            opn_q <= opn_q | open_a_q;
            if (!avg_q || cnt_q == `TRM_AVG_LAST) begin
              sq_q <= SQ_STORE;
            end else begin
              cnt_q <= cnt_q + 4'h1;
              sq_q <= SQ_START;
            end
          end
        end
        default: begin
          ch_q <= (ch_q == CH_REM_B) ? CH_LOCAL : trm_chan_t'(ch_q + 2'b01);
          cnt_q <= 4'h0;
          acc_q <= 16'sh0000;
          opn_q <= 1'b0;
          sq_q <= SQ_START;
        end
      endcase
    end
  end

  // Result formatting and limit comparison at the end of each visit.
  wire trm_sample_t avg_w = avg_q ? trm_sample_t'(acc_q >>> `TRM_AVG_SHIFT) : acc_q[11:0];
  wire [9:0] fmt_w = fmt_q(avg_w, cfg_q[`TRM_CFG_RANGE]);
  wire [3:0] base_w = {ch_q, 1'b0} + {2'b00, ch_q};
  wire [7:0] cur_w = fmt_w[9:2];
  wire store_w = sq_q == SQ_STORE;
  wire rem_w = ch_q != CH_LOCAL;
  wire rix_w = ch_q == CH_REM_B;

  always_ff @(posedge core_clk_i) begin
    if (reset_i) begin
      loc_q <= 8'h00;
      hi_lat_q[0] <= 8'h00;
      hi_lat_q[1] <= 8'h00;
      lo_lat_q[0] <= 2'b00;
      lo_lat_q[1] <= 2'b00;
      hf_q <= 3'b000;
      lf_q <= 3'b000;
      of_q <= 3'b000;
      open_q <= 2'b00;
    end else if (store_w) begin
      if (!rem_w) begin
        loc_q <= cur_w;
      end else if (!opn_q) begin
        hi_lat_q[rix_w] <= cur_w;
        lo_lat_q[rix_w] <= fmt_w[1:0];
      end
      if (rem_w) begin
        open_q[rix_w] <= opn_q;
      end
      hf_q[ch_q] <= ~(rem_w & opn_q) & (cur_w > lim_q[base_w]);
      lf_q[ch_q] <= ~(rem_w & opn_q) & (cur_w < lim_q[base_w + 4'h1]);
      of_q[ch_q] <= ~(rem_w & opn_q) & (cur_w > lim_q[base_w + 4'h2]);
    end
  end

  // Alarm pins follow the live flags, never the frozen high bytes.
  wire ra_alarm = ~cfg_q[`TRM_CFG_MASK_RA] & (hf_q[1] | lf_q[1] | open_q[0]);
  wire rb_alarm = ~cfg_q[`TRM_CFG_MASK_RB] & (hf_q[2] | lf_q[2] | open_q[1]);
  wire alert_w = ~cfg_q[`TRM_CFG_MASK_ALL] & (hf_q[0] | lf_q[0] | ra_alarm | rb_alarm);
  wire ot_w = |of_q;
  wire pin2_w = pin_role_select ? ot_w : alert_w;
  logic ot_oe_n_q, al_oe_n_q, drv_low_q;

  // The alarm pins are released in standby because the flags there are stale.
  always_ff @(posedge core_clk_i) begin
    if (reset_i) begin
      ot_oe_n_q <= 1'b1;
      al_oe_n_q <= 1'b1;
      drv_low_q <= 1'b0;
    end else begin
      ot_oe_n_q <= ~(ot_w & ~standby_select);
      al_oe_n_q <= ~(pin2_w & ~standby_select);
      drv_low_q <= 1'b0;
    end
  end

  assign sda_o = drv_low_q;
  assign overtemp_out_n_o = drv_low_q;
  assign overtemp_oe_n_o = ot_oe_n_q;
  assign alert_out_n_o = drv_low_q;
  assign alert_oe_n_o = al_oe_n_q;
endmodule

/* dv/trm_top_props.sv */
// Concurrent checks on the temperature monitor ports.
`timescale 1ns/1ps
module trm_top_props (
  input wire logic core_clk_i,
  input wire logic reset_i,
  input wire logic scl_i,
  input wire logic sda_i,
  input wire logic sda_o,
  input wire logic sda_oe_n_o,
  input wire logic overtemp_out_n_o,
  input wire logic overtemp_oe_n_o,
  input wire logic alert_out_n_o,
  input wire logic alert_oe_n_o,
  input wire logic adc_clk_i,
  input wire logic adc_start_o,
  input wire trm_pkg::trm_chan_t adc_chan_o,
  input wire logic adc_done_i,
  input wire trm_pkg::trm_sample_t adc_data_i,
  input wire logic adc_open_i
);
  import trm_pkg::*;
  sequence quiet_s;
    !adc_start_o [*3];
  endsequence
  sequence req_s;
    ##[1:300] adc_start_o;
  endsequence
  sda_value_a: assert property (@(posedge core_clk_i) disable iff (reset_i)
    sda_o == 1'b0) else $error("data pin value not low");
  alarm_value_a: assert property (@(posedge core_clk_i) disable iff (reset_i)
    overtemp_out_n_o == 1'b0 && alert_out_n_o == 1'b0) else $error("alarm pin value not low");
  reset_release_a: assert property (@(posedge core_clk_i) disable iff (reset_i)
    $fell(reset_i) |-> sda_oe_n_o && overtemp_oe_n_o && alert_oe_n_o)
    else $error("pins not released out of reset");
  sda_change_a: assert property (@(posedge core_clk_i) disable iff (reset_i)
    $changed(sda_oe_n_o) |-> !scl_i) else $error("data pin moved with clock high");
  first_request_a: assert property (@(posedge core_clk_i) disable iff (reset_i)
    $fell(reset_i) |-> req_s) else $error("no conversion after reset");
  adc_pulse_a: assert property (@(posedge adc_clk_i) disable iff (reset_i)
    $rose(adc_start_o) |=> quiet_s) else $error("start not a lone pulse");
  chan_hold_a: assert property (@(posedge adc_clk_i) disable iff (reset_i)
    !$rose(adc_start_o) |-> $stable(adc_chan_o)) else $error("channel moved between starts");
  chan_legal_a: assert property (@(posedge adc_clk_i) disable iff (reset_i)
    adc_chan_o != 2'b11) else $error("illegal channel");
endmodule
bind trm_top trm_top_props trm_top_props_inst (.core_clk_i(core_clk_i), .reset_i(reset_i),
  .scl_i(scl_i), .sda_i(sda_i), .sda_o(sda_o), .sda_oe_n_o(sda_oe_n_o),
  .overtemp_out_n_o(overtemp_out_n_o), .overtemp_oe_n_o(overtemp_oe_n_o),
  .alert_out_n_o(alert_out_n_o), .alert_oe_n_o(alert_oe_n_o), .adc_clk_i(adc_clk_i),
  .adc_start_o(adc_start_o), .adc_chan_o(adc_chan_o), .adc_done_i(adc_done_i),
  .adc_data_i(adc_data_i), .adc_open_i(adc_open_i));

/* dv/trm_host.sv */
// Two-wire bus host model driving the clock and data pins.
`timescale 1ns/1ps
module trm_host #(
  parameter logic [6:0] DEV_ADDR = 7'h2a
) (
  input wire logic core_clk_i,
  input wire logic sda_i,
  output logic scl_o,
  output logic sda_o
);
  initial begin
    scl_o = 1'b1;
    sda_o = 1'b1;
  end
  task automatic hp();
    repeat (16) @(negedge core_clk_i);
  endtask
  // Data moves a few cycles after the clock fall so it never races a start or stop.
  task automatic bit_io(input logic b, output logic s);
    repeat (4) @(negedge core_clk_i);
    sda_o = b;
    hp();
    scl_o = 1'b1;
    hp();
    s = sda_i;
    scl_o = 1'b0;
  endtask
  task automatic start();
    repeat (4) @(negedge core_clk_i);
    sda_o = 1'b1;
    hp();
    scl_o = 1'b1;
    hp();
    sda_o = 1'b0;
    hp();
    scl_o = 1'b0;
  endtask
  task automatic stop();
    repeat (4) @(negedge core_clk_i);
    sda_o = 1'b0;
    hp();
    scl_o = 1'b1;
    hp();
    sda_o = 1'b1;
    hp();
  endtask
  // The ack slot is released: the device acks writes and reads end with a NACK.
  task automatic xfer(input logic [7:0] w, output logic [7:0] r);
    logic a;
    for (int i = 7; i >= 0; i--) begin
      bit_io(w[i], r[i]);
    end
    bit_io(1'b1, a);
  endtask
  task automatic wr(input logic [7:0] ptr, input logic [7:0] d);
    logic [7:0] x;
    start();
    xfer({DEV_ADDR, 1'b0}, x);
    xfer(ptr, x);
    xfer(d, x);
    stop();
  endtask
  task automatic rd(input logic [7:0] ptr, input bit keep, output logic [7:0] d);
    logic [7:0] x;
    start();
    xfer({DEV_ADDR, 1'b0}, x);
    xfer(ptr, x);
    start();
    xfer({DEV_ADDR, 1'b1}, x);
    xfer(8'hff, d);
    if (!keep) stop();
  endtask
endmodule

/* dv/tb.sv */
// Self-checking bench for the temperature monitor back end.
`timescale 1ns/1ps
module tb;
  import trm_pkg::*;
  logic core_clk, adc_clk, reset, h_scl, h_sda, adc_done, adc_open, wob, tog;
  logic sda_o, sda_oe_n, ot_out, ot_oe_n, al_out, al_oe_n, adc_start;
  logic [2:0] opn;
  wire logic sda_w;
  trm_chan_t adc_chan, cur;
  trm_sample_t adc_data;
  trm_sample_t temp [3];
  int pend, err_total, checks_done;
  // The line has a pull-up; the device only sinks it.
  assign sda_w = h_sda & sda_oe_n;
  initial begin
    core_clk = 1'b0;
    forever #2.5 core_clk = ~core_clk;
  end
  initial begin
    adc_clk = 1'b0;
    #7;
    forever #24 adc_clk = ~adc_clk;
  end
  trm_top #(.SLAVE_ADDR(7'h2a)) trm_top_inst (.core_clk_i(core_clk), .reset_i(reset),
    .scl_i(h_scl), .sda_i(sda_w), .sda_o(sda_o), .sda_oe_n_o(sda_oe_n),
    .overtemp_out_n_o(ot_out), .overtemp_oe_n_o(ot_oe_n), .alert_out_n_o(al_out),
    .alert_oe_n_o(al_oe_n), .adc_clk_i(adc_clk), .adc_start_o(adc_start),
    .adc_chan_o(adc_chan), .adc_done_i(adc_done), .adc_data_i(adc_data),
    .adc_open_i(adc_open));
  trm_host #(.DEV_ADDR(7'h2a)) trm_host_inst (.core_clk_i(core_clk), .sda_i(sda_w),
    .scl_o(h_scl), .sda_o(h_sda));
  // Front end answers each request after three cycles; outside that cycle the data toggles.
  always @(negedge adc_clk) begin
    adc_done <= (pend == 1);
    adc_data <= (pend == 1) ? temp[cur] + ((wob && tog) ? 12'sh004 : 12'sh000) : ~adc_data;
    adc_open <= (pend == 1) ? opn[cur] : ~adc_open;
    if (pend == 1) tog <= ~tog;
    if (pend > 0) pend <= pend - 1;
    else if (adc_start === 1'b1) begin
      pend <= 3;
      cur <= adc_chan;
    end
  end
  task automatic chk_byte(input string what, input logic [7:0] exp, input logic [7:0] got);
    checks_done++;
    if (got !== exp) begin
      err_total++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic chk_pin(input string what, input logic exp, input logic got);
    checks_done++;
    if (got !== exp) begin
      err_total++;
      $display("CHECK FAILED %s expected %b seen %b", what, exp, got);
    end
  endtask
  task automatic reg_is(input logic [7:0] ptr, input bit keep, input logic [7:0] exp);
    logic [7:0] d;
    trm_host_inst.rd(ptr, keep, d);
    chk_byte($sformatf("register %h", ptr), exp, d);
  endtask
  task automatic wr(input logic [7:0] ptr, input logic [7:0] d);
    trm_host_inst.wr(ptr, d);
  endtask
  task automatic settle(input int n);
    repeat (n) @(posedge adc_start);
    @(negedge core_clk);
  endtask
  task automatic t_lock();
    reg_is(8'h10, 0, 8'h80);
    temp[1] = 12'sh190;
    settle(7);
    chk_pin("alert pin", 1'b0, al_oe_n);
    chk_pin("overtemp pin", 1'b0, ot_oe_n);
    reg_is(8'h01, 0, 8'h1e);
    reg_is(8'h01, 0, 8'h64);
    reg_is(8'h10, 1, 8'h00);
    temp[1] = 12'sh050;
    settle(7);
    reg_is(8'h01, 0, 8'h14);
    $display("t_lock done");
  endtask
  task automatic t_alarm();
    wr(8'h41, 8'h1e);
    settle(7);
    chk_pin("alert pin", 1'b0, al_oe_n);
    chk_pin("overtemp pin", 1'b1, ot_oe_n);
    reg_is(8'h02, 0, 8'h02);
    wr(8'h09, 8'h20);
    settle(7);
    chk_pin("alert pin", 1'b1, al_oe_n);
    temp[1] = 12'sh190;
    settle(7);
    chk_pin("alert pin", 1'b0, al_oe_n);
    chk_pin("overtemp pin", 1'b0, ot_oe_n);
    wr(8'h09, 8'h60);
    chk_pin("alert pin", 1'b1, al_oe_n);
    chk_pin("overtemp pin", 1'b1, ot_oe_n);
    reg_is(8'h03, 0, 8'h60);
    wr(8'h09, 8'h00);
    wr(8'h41, 8'h00);
    temp[1] = 12'sh050;
    opn = 3'b100;
    settle(7);
    chk_pin("alert pin", 1'b0, al_oe_n);
    reg_is(8'h02, 0, 8'h80);
    wr(8'h09, 8'h01);
    chk_pin("alert pin", 1'b1, al_oe_n);
    wr(8'h09, 8'h00);
    opn = 3'b000;
    settle(7);
    $display("t_alarm done");
  endtask
  task automatic t_format();
    temp = '{12'sh258, -12'sh0dc, 12'sh02b};
    settle(7);
    reg_is(8'h00, 0, 8'h7f);
    reg_is(8'h10, 0, 8'h00);
    reg_is(8'h01, 0, 8'h00);
    reg_is(8'h33, 0, 8'hc0);
    reg_is(8'h30, 0, 8'h0a);
    wr(8'h09, 8'h08);
    reg_is(8'h10, 0, 8'hc0);
    reg_is(8'h01, 0, 8'h0a);
    wr(8'h09, 8'h04);
    settle(7);
    reg_is(8'h00, 0, 8'hd6);
    reg_is(8'h10, 0, 8'h00);
    reg_is(8'h01, 0, 8'h09);
    reg_is(8'h40, 0, 8'h55);
    wr(8'h40, 8'h95);
    reg_is(8'h7f, 0, 8'h00);
    reg_is(8'h03, 0, 8'h04);
    $display("t_format done");
  endtask
  task automatic t_avg();
    temp[1] = 12'sh050;
    wob = 1'b1;
    wr(8'h0a, 8'h04);
    settle(100);
    reg_is(8'h10, 0, 8'h80);
    reg_is(8'h01, 0, 8'h54);
    wob = 1'b0;
    $display("t_avg done");
  endtask
  task automatic summarize();
    $display("checks %0d mismatches %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  initial begin
    // Well above the expected run time, yet below the overall cycle budget.
    #480us;
    err_total++;
    $display("CHECK FAILED watchdog expected done seen hang");
    summarize();
  end
  initial begin
    reset = 1'b1;
    err_total = 0;
    checks_done = 0;
    pend = 0;
    wob = 1'b0;
    tog = 1'b0;
    opn = 3'b000;
    adc_done = 1'b0;
    adc_open = 1'b0;
    adc_data = 12'sh000;
    temp = '{12'sh064, 12'sh07a, 12'sh000};
    // The front-end domain needs several of its own edges inside reset.
    repeat (32) @(negedge core_clk);
    reset = 1'b0;
    settle(7);
    t_lock();
    t_alarm();
    t_format();
    t_avg();
    summarize();
  end
endmodule
